// *** design/lor_cfg_regs.sv ***
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Function
// - Link B extra-lane bits 7:1 enable lane n clocks regardless of mode.
// - Bit 0 zero: clocks only; one: extra serializers also run.
// - Extra lanes follow current link mode and test pattern settings.
// - Extra-only lanes send octet ramp when test pattern is 0 or 5.
// - Channel power-down keeps extra lanes inactive.
// - Serializer n clocked only when lanes 0..n-1 are all enabled.
// - Sync-header field: 0 CRC-12, 2 FEC, 1 and 3 reserved.
// - Sync-header select applies only in 64b/66b link modes.
// - Command fields of sync word are always zero.
// - DDC gain bit: 0 gives 0dB, 1 adds 6.02dB.
// - Threshold-0, reset F2, sets control bit 0 on I samples.
// - Threshold-1, reset AB, sets control bit 1 on Q samples.
// - Threshold T means 20log10(T/256) dBFS peak level.
module lor_cfg_regs #(
  parameter int SW = 16
) (
  // Clock, reset, enable
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          clk_en,
  // Register port
  input  wire logic [11:0]   reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [7:0]    reg_rdata,
  // Link layer context
  input  wire logic          serial_link_enable,
  input  wire logic [7:0]    mode_lane_mask,
  input  wire logic          mode_is_64b66b,
  input  wire logic [3:0]    link_test_pattern,
  input  wire logic          channel_power_down,
  // Lane controls
  output logic      [7:0]    lane_clk_en,
  output logic      [7:0]    lane_ser_en,
  output logic      [7:0]    lane_force_ramp,
  output logic      [3:0]    lane_pattern,
  // Sync header controls
  output logic               sh_send_crc,
  output logic               sh_send_fec,
  output logic      [31:0]   sh_cmd_bits,
  // DDC
  output logic               ddc_gain_double,
  input  wire logic [SW-1:0] ddc_i_sample,
  input  wire logic [SW-1:0] ddc_q_sample,
  input  wire logic          ddc_valid,
  output logic      [SW-1:0] ddc_i_out,
  output logic      [SW-1:0] ddc_q_out,
  output logic               ddc_ctrl_bit0,
  output logic               ddc_ctrl_bit1,
  output logic               ddc_out_valid
);
  //////////////////////////////////////////////////////////////////////////////
  logic       rst_s1_r;
  logic       rst_sync_r;
  logic [7:0] extra_lane_enable_b_r;
  logic [1:0] sync_header_select_r;
  logic       ddc_gain_config_r;
  logic [7:0] overrange_threshold_i_r;
  logic [7:0] overrange_threshold_q_r;
  logic [7:0] lane_clk_nxt;
  logic [7:0] lane_ser_nxt;
  logic [7:0] ramp_nxt;
  lor_pkg::lor_sh_type sh_state_r;
  lor_pkg::lor_sh_type sh_state_nxt;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r   <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_s1_r   <= 1'b1;
      rst_sync_r <= rst_s1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register writes; software keeps link disabled for lane and header changes
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      extra_lane_enable_b_r   <= lor_pkg::EXTRA_LANE_ENABLE_B_RST;
      sync_header_select_r    <= lor_pkg::SYNC_HEADER_SELECT_RST[1:0];
      ddc_gain_config_r       <= lor_pkg::DDC_GAIN_CONFIG_RST[0];
      overrange_threshold_i_r <= lor_pkg::OVERRANGE_THRESHOLD_I_RST;
      overrange_threshold_q_r <= lor_pkg::OVERRANGE_THRESHOLD_Q_RST;
    end else if (clk_en && reg_wr) begin
      unique case (reg_addr)
        lor_pkg::EXTRA_LANE_ENABLE_B_ADDR:   extra_lane_enable_b_r   <= reg_wdata;
        lor_pkg::SYNC_HEADER_SELECT_ADDR:    sync_header_select_r    <= reg_wdata[1:0];
        lor_pkg::DDC_GAIN_CONFIG_ADDR:       ddc_gain_config_r       <= reg_wdata[lor_pkg::DDC_GAIN_DOUBLE_BIT];
        lor_pkg::OVERRANGE_THRESHOLD_I_ADDR: overrange_threshold_i_r <= reg_wdata;
        lor_pkg::OVERRANGE_THRESHOLD_Q_ADDR: overrange_threshold_q_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data registered; unmapped reads zero
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      unique case (reg_addr)
        lor_pkg::EXTRA_LANE_ENABLE_B_ADDR:   reg_rdata <= extra_lane_enable_b_r;
        lor_pkg::SYNC_HEADER_SELECT_ADDR:    reg_rdata <= {6'h00, sync_header_select_r};
        lor_pkg::DDC_GAIN_CONFIG_ADDR:       reg_rdata <= {7'h00, ddc_gain_config_r};
        lor_pkg::OVERRANGE_THRESHOLD_I_ADDR: reg_rdata <= overrange_threshold_i_r;
        lor_pkg::OVERRANGE_THRESHOLD_Q_ADDR: reg_rdata <= overrange_threshold_q_r;
        default:                             reg_rdata <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lane enables
  always_comb begin
    logic [7:0] want;
    logic       chain;
    want  = mode_lane_mask | {extra_lane_enable_b_r[7:1], 1'b0};
    chain = 1'b1;
    lane_clk_nxt = 8'h00;
    lane_ser_nxt = 8'h00;
    ramp_nxt     = 8'h00;
    for (int n = 0; n < lor_pkg::NUM_LANES; n++) begin
      lane_clk_nxt[n] = want[n] && !channel_power_down;
      // Serializer clock passes only along an unbroken chain from lane 0
      lane_ser_nxt[n] = lane_clk_nxt[n] && chain &&
                        (mode_lane_mask[n] || extra_lane_enable_b_r[lor_pkg::SPARE_SER_BIT]);
      chain = chain && lane_clk_nxt[n];
      ramp_nxt[n] = lane_clk_nxt[n] && !mode_lane_mask[n] &&
                    (link_test_pattern == lor_pkg::TP_NONE || link_test_pattern == lor_pkg::TP_ALT);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      lane_clk_en     <= 8'h00;
      lane_ser_en     <= 8'h00;
      lane_force_ramp <= 8'h00;
      lane_pattern    <= lor_pkg::TP_NONE;
    end else if (clk_en) begin
      lane_clk_en     <= lane_clk_nxt;
      lane_ser_en     <= lane_ser_nxt;
      lane_force_ramp <= ramp_nxt;
      // Shared pattern is ramp code 4 for all lanes when any lane is forced; otherwise the link pattern
      lane_pattern    <= (|ramp_nxt) ? lor_pkg::TP_RAMP : link_test_pattern;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sync header content; reserved codes fall back to idle, no content
  always_comb begin
    sh_state_nxt = lor_pkg::LOR_SH_IDLE;
    if (serial_link_enable && mode_is_64b66b) begin
      if (sync_header_select_r == lor_pkg::SH_CRC12) begin
        sh_state_nxt = lor_pkg::LOR_SH_CRC;
      end else if (sync_header_select_r == lor_pkg::SH_FEC) begin
        sh_state_nxt = lor_pkg::LOR_SH_FEC;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      sh_state_r <= lor_pkg::LOR_SH_IDLE;
    end else if (clk_en) begin
      sh_state_r <= sh_state_nxt;
    end
  end

  always_comb begin
    sh_send_crc = 1'b0;
    sh_send_fec = 1'b0;
    unique case (sh_state_r)
      lor_pkg::LOR_SH_IDLE: ;
      lor_pkg::LOR_SH_CRC:  sh_send_crc = 1'b1;
      lor_pkg::LOR_SH_FEC:  sh_send_fec = 1'b1;
      default: ;
    endcase
  end

  // No command channel: 32-bit field stays zero
  assign sh_cmd_bits = 32'h0000_0000;

  // Gain ddc_gain_double level for the filter; software guards against clipping
  assign ddc_gain_double = ddc_gain_config_r;

  //////////////////////////////////////////////////////////////////////////////
  // Over-range control bits
  lor_ovr_if #(.SW(SW)) ovr_i ();
  lor_ovr_if #(.SW(SW)) ovr_q ();

  assign ovr_i.sample    = ddc_i_sample;
  assign ovr_i.threshold = overrange_threshold_i_r;
  assign ovr_i.valid     = ddc_valid;
  assign ovr_q.sample    = ddc_q_sample;
  assign ovr_q.threshold = overrange_threshold_q_r;
  assign ovr_q.valid     = ddc_valid;

  lor_ovr_det #(.SW(SW)) u_det_i (
    .ref_clk (ref_clk),
    .rst_n   (rst_sync_r),
    .clk_en  (clk_en),
    .port    (ovr_i)
  );

  lor_ovr_det #(.SW(SW)) u_det_q (
    .ref_clk (ref_clk),
    .rst_n   (rst_sync_r),
    .clk_en  (clk_en),
    .port    (ovr_q)
  );

  // Samples delayed one cycle to stay aligned with their flags
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ddc_i_out     <= '0;
      ddc_q_out     <= '0;
      ddc_out_valid <= 1'b0;
    end else if (clk_en) begin
      ddc_out_valid <= ddc_valid;
      if (ddc_valid) begin
        ddc_i_out <= ddc_i_sample;
        ddc_q_out <= ddc_q_sample;
      end
    end
  end

  assign ddc_ctrl_bit0 = ovr_i.flag;
  assign ddc_ctrl_bit1 = ovr_q.flag;
endmodule

// *** design/lor_ovr_det.sv ***
`timescale 1ns/1ps
module lor_ovr_det #(
  parameter int SW = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Sample and flag
  lor_ovr_if.det   port
);
  logic [SW-1:0] mag;
  logic          flag_r;

  // Two's complement magnitude; most negative saturates
  always_comb begin
    if (port.sample[SW-1]) begin
      mag = (port.sample == {1'b1, {(SW-1){1'b0}}}) ? {1'b0, {(SW-1){1'b1}}} : SW'(-port.sample);
    end else begin
      mag = port.sample;
    end
  end

  // Top eight magnitude bits compared as T/256 of full scale
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (clk_en && port.valid) begin
      flag_r <= (mag[SW-2 -: 8] >= port.threshold);
    end
  end

  assign port.flag = flag_r;
endmodule

// *** design/lor_ovr_if.sv ***
`timescale 1ns/1ps
interface lor_ovr_if #(parameter int SW = 16);
  logic [SW-1:0] sample;
  logic [7:0]    threshold;
  logic          valid;
  logic          flag;
  modport det (input sample, input threshold, input valid, output flag);
  modport ctl (output sample, output threshold, output valid, input flag);
endinterface

// *** design/lor_pkg.sv ***
package lor_pkg;
  // Register offsets on the device register port
  localparam logic [11:0] SYNC_HEADER_SELECT_ADDR    = 12'h20F;
  localparam logic [11:0] DDC_GAIN_CONFIG_ADDR       = 12'h210;
  localparam logic [11:0] OVERRANGE_THRESHOLD_I_ADDR = 12'h211;
  localparam logic [11:0] OVERRANGE_THRESHOLD_Q_ADDR = 12'h212;
  localparam logic [11:0] EXTRA_LANE_ENABLE_B_ADDR   = 12'h20B;

  // Reset values
  localparam logic [7:0] SYNC_HEADER_SELECT_RST    = 8'h00;
  localparam logic [7:0] DDC_GAIN_CONFIG_RST       = 8'h00;
  localparam logic [7:0] OVERRANGE_THRESHOLD_I_RST = 8'hF2;
  localparam logic [7:0] OVERRANGE_THRESHOLD_Q_RST = 8'hAB;
  localparam logic [7:0] EXTRA_LANE_ENABLE_B_RST   = 8'h00;

  // Field positions
  localparam int SPARE_SER_BIT  = 0;
  localparam int DDC_GAIN_DOUBLE_BIT      = 0;
  localparam int NUM_LANES      = 8;

  // Sync header content codes
  localparam logic [1:0] SH_CRC12 = 2'h0;
  localparam logic [1:0] SH_FEC   = 2'h2;

  // Test pattern codes
  localparam logic [3:0] TP_NONE  = 4'h0;
  localparam logic [3:0] TP_RAMP  = 4'h4;
  localparam logic [3:0] TP_ALT   = 4'h5;

  typedef enum logic [2:0] {
    LOR_SH_IDLE  = 3'b001,
    LOR_SH_CRC   = 3'b010,
    LOR_SH_FEC   = 3'b100
  } lor_sh_type;
endpackage

// *** dv/lor_cfg_regs_checker.sv ***
`timescale 1ns/1ps
module lor_cfg_regs_checker #(
  parameter int SW = 16
) (
  // Clock, reset, enable
  input wire logic          ref_clk,
  input wire logic          rst_n,
  input wire logic          clk_en,
  // DDC path
  input wire logic          ddc_valid,
  input wire logic [SW-1:0] ddc_i_sample,
  input wire logic [SW-1:0] ddc_q_sample,
  input wire logic [SW-1:0] ddc_i_out,
  input wire logic [SW-1:0] ddc_q_out,
  input wire logic          ddc_out_valid,
  // Lane and sync header state
  input wire logic          channel_power_down,
  input wire logic [7:0]    lane_clk_en,
  input wire logic [7:0]    lane_ser_en,
  input wire logic [7:0]    lane_force_ramp,
  input wire logic [3:0]    lane_pattern,
  input wire logic          sh_send_crc,
  input wire logic          sh_send_fec,
  input wire logic [31:0]   sh_cmd_bits,
  input wire logic          serial_link_enable,
  input wire logic          mode_is_64b66b
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Lanes below n all clocked
  logic [7:0] pre;
  always_comb begin
    pre[0] = 1'b1;
    for (int n = 1; n < 8; n++) pre[n] = pre[n-1] & lane_clk_en[n-1];
  end
  property p_cmd_zero; sh_cmd_bits == 32'h0; endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("sync command bits not idle");
  property p_sh_excl; !(sh_send_crc && sh_send_fec); endproperty
  a_sh_excl: assert property (p_sh_excl) else $error("crc and fec both selected");
  // Header content only while the link runs in 64b66b
  property p_sh_off;
    $past(clk_en && !(serial_link_enable && mode_is_64b66b)) |-> !sh_send_crc && !sh_send_fec;
  endproperty
  a_sh_off: assert property (p_sh_off) else $error("sync content sent outside 64b66b link");
  property p_dv_lat; $past(ddc_valid && clk_en) |-> ddc_out_valid; endproperty
  a_dv_lat: assert property (p_dv_lat) else $error("sample valid not forwarded");
  property p_i_pass; $past(ddc_valid && clk_en) |-> ddc_i_out == $past(ddc_i_sample); endproperty
  a_i_pass: assert property (p_i_pass) else $error("i sample mismatch");
  property p_q_pass; $past(ddc_valid && clk_en) |-> ddc_q_out == $past(ddc_q_sample); endproperty
  a_q_pass: assert property (p_q_pass) else $error("q sample mismatch");
  property p_ser_chain; (lane_ser_en & ~(pre & lane_clk_en)) == 8'h00; endproperty
  a_ser_chain: assert property (p_ser_chain) else $error("serializer without lower lanes");
  property p_pd; channel_power_down [*3] |-> lane_clk_en == 8'h00 && lane_ser_en == 8'h00; endproperty
  a_pd: assert property (p_pd) else $error("lanes active in power down");
  property p_ramp_pat; lane_force_ramp != 8'h00 |-> lane_pattern == 4'h4; endproperty
  a_ramp_pat: assert property (p_ramp_pat) else $error("forced ramp without ramp code");
endmodule
bind lor_cfg_regs lor_cfg_regs_checker #(.SW(SW)) i_lor_cfg_regs_checker (.ref_clk(ref_clk), .rst_n(rst_n),
  .clk_en(clk_en), .ddc_valid(ddc_valid), .ddc_i_sample(ddc_i_sample), .ddc_q_sample(ddc_q_sample),
  .ddc_i_out(ddc_i_out), .ddc_q_out(ddc_q_out), .ddc_out_valid(ddc_out_valid),
  .channel_power_down(channel_power_down), .lane_clk_en(lane_clk_en), .lane_ser_en(lane_ser_en),
  .lane_force_ramp(lane_force_ramp), .lane_pattern(lane_pattern), .sh_send_crc(sh_send_crc),
  .sh_send_fec(sh_send_fec), .sh_cmd_bits(sh_cmd_bits), .serial_link_enable(serial_link_enable),
  .mode_is_64b66b(mode_is_64b66b));

// *** dv/lor_cfg_regs_tb_top.sv ***
`timescale 1ns/1ps
module lor_cfg_regs_tb_top;
  logic ref_clk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, lnk = 0, m64 = 0, pd = 0, dv = 0;
  logic [11:0] addr = 12'h000;
  logic [7:0]  wd = 8'h00, mask = 8'h00, rdata, lclk, lser, lramp, t0 = 8'hF2, t1 = 8'hAB;
  logic [3:0]  tp = 4'h0, lpat;
  logic [15:0] si = 16'h0000, sq = 16'h0000, io, qo;
  logic        crc, fec, gain, b0, b1, ov, rd_d = 0, dv_d = 0;
  logic [31:0] s = 32'h2260, cmd;
  logic [7:0]  rq[$];
  logic [33:0] dq[$];
  int err_total = 0, total_checks = 0, cyc = 0;
  // extra, mask, tp, pd, clk, ser, ramp, pattern
  localparam logic [51:0] LT [7] = '{{8'h07,8'h01,4'h0,4'h0,8'h07,8'h07,8'h06,4'h4},
    {8'h07,8'h01,4'h5,4'h0,8'h07,8'h07,8'h06,4'h4}, {8'h07,8'h01,4'h3,4'h0,8'h07,8'h07,8'h00,4'h3},
    {8'h06,8'h01,4'h0,4'h0,8'h07,8'h01,8'h06,4'h4}, {8'h09,8'h01,4'h3,4'h0,8'h09,8'h01,8'h00,4'h3},
    {8'h0F,8'h01,4'h3,4'h0,8'h0F,8'h0F,8'h00,4'h3}, {8'h07,8'h01,4'h3,4'h1,8'h00,8'h00,8'h00,4'h3}};
  lor_cfg_regs i_lor_cfg_regs (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(addr),
    .reg_wdata(wd), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .serial_link_enable(lnk),
    .mode_lane_mask(mask), .mode_is_64b66b(m64), .link_test_pattern(tp), .channel_power_down(pd),
    .lane_clk_en(lclk), .lane_ser_en(lser), .lane_force_ramp(lramp), .lane_pattern(lpat), .sh_send_crc(crc),
    .sh_send_fec(fec), .sh_cmd_bits(cmd), .ddc_gain_double(gain), .ddc_i_sample(si), .ddc_q_sample(sq),
    .ddc_valid(dv), .ddc_i_out(io), .ddc_q_out(qo), .ddc_ctrl_bit0(b0), .ddc_ctrl_bit1(b1), .ddc_out_valid(ov));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Most negative code saturates before truncation
  function automatic logic fl(input logic [15:0] v, input logic [7:0] t);
    logic [15:0] m;
    m = v[15] ? ((v == 16'h8000) ? 16'h7FFF : -v) : v;
    return m[14:7] >= t;
  endfunction
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    addr = a; wd = d; reg_wr = 1;
    if (a == 12'h211) t0 = d;
    if (a == 12'h212) t1 = d;
    @(negedge ref_clk);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    addr = a; reg_rd = 1;
    rq.push_back(e);
    @(negedge ref_clk);
    reg_rd = 0;
  endtask
  task automatic smp(input logic [15:0] i, input logic [15:0] q);
    @(negedge ref_clk);
    si = i; sq = q; dv = 1;
    dq.push_back({i, q, fl(i, t0), fl(q, t1)});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Monitor: result appears one edge after its request
  always @(posedge ref_clk) begin
    rd_d <= reg_rd & clk_en;
    dv_d <= dv & clk_en;
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim;
    end
  end
  always @(negedge ref_clk) begin
    if (rd_d) chk("reg_rdata", {26'h0, rq.pop_front()}, {26'h0, rdata});
    if (dv_d) chk("ddc_out", dq.pop_front(), {io, qo, b0, b1});
    chk("ddc_out_valid", {33'h0, dv_d}, {33'h0, ov});
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge ref_clk);
    rst_n = 1;
    repeat (4) @(negedge ref_clk);
    rd(12'h20F, 8'h00);
    rd(12'h210, 8'h00);
    rd(12'h211, 8'hF2);
    rd(12'h212, 8'hAB);
    rd(12'h20B, 8'h00);
    rd(12'h213, 8'h00);
    wr(12'h210, 8'hFF);
    rd(12'h210, 8'h01);
    chk("ddc_gain_double", 34'h1, {33'h0, gain});
    wr(12'h20F, 8'hFF);
    rd(12'h20F, 8'h03);
    for (int c = 0; c < 4; c++) begin
      wr(12'h20F, c[7:0]);
      lnk = 1; m64 = 1;
      repeat (3) @(negedge ref_clk);
      chk("sync_header", {32'h0, c == 0, c == 2}, {32'h0, crc, fec});
      chk("sh_cmd_bits", 34'h0, {2'b00, cmd});
      m64 = 0;
      repeat (3) @(negedge ref_clk);
      chk("sync_header_8b10b", 34'h0, {32'h0, crc, fec});
      lnk = 0;
    end
    for (int k = 0; k < 7; k++) begin
      wr(12'h20B, LT[k][51:44]);
      mask = LT[k][43:36]; tp = LT[k][35:32]; pd = LT[k][28]; lnk = 1;
      repeat (4) @(negedge ref_clk);
      chk("lane_clk_en", {26'h0, LT[k][27:20]}, {26'h0, lclk});
      chk("lane_ser_en", {26'h0, LT[k][19:12]}, {26'h0, lser});
      chk("lane_ramp", {22'h0, LT[k][11:0]}, {22'h0, lramp, lpat});
      lnk = 0; pd = 0;
    end
    wr(12'h211, 8'h80);
    wr(12'h212, 8'h40);
    smp(16'h4000, 16'h2000);
    smp(16'h3F80, 16'h1FFF);
    smp(16'hC000, 16'hE000);
    smp(16'h8000, 16'hE001);
    @(negedge ref_clk);
    dv = 0;
    wr(12'h211, s[7:0]);
    for (int k = 0; k < 40; k++) begin
      s = lfsr(s);
      smp(s[15:0], s[31:16]);
    end
    @(negedge ref_clk);
    dv = 0;
    repeat (4) @(negedge ref_clk);
    // Frozen clock enable must drop the write
    clk_en = 0;
    wr(12'h212, 8'h11);
    clk_en = 1;
    rd(12'h212, 8'h40);
    // Mid-run reset restores defaults
    @(negedge ref_clk);
    rst_n = 0;
    repeat (3) @(negedge ref_clk);
    rst_n = 1;
    repeat (4) @(negedge ref_clk);
    rd(12'h211, 8'hF2);
    rd(12'h210, 8'h00);
    @(negedge ref_clk);
    chk("ddc_gain_double", 34'h0, {33'h0, gain});
    chk("queue_left", 34'h0, 34'(dq.size() + rq.size()));
    end_sim;
  end
endmodule
